// file: dmx5_consts.svh
`ifndef DMX5_CONSTS_SVH
`define DMX5_CONSTS_SVH

// ----------------------------------------------------------------
// Widths and clock
// ----------------------------------------------------------------
`define DMX5_AW          9
`define DMX5_DW          5
`define DMX5_CNT_W       11
`define DMX5_CLK_NS      8

// ----------------------------------------------------------------
// Memory timing, in ns unless named otherwise
// ----------------------------------------------------------------
`define DMX5_T_RCD_NS    30
`define DMX5_T_RAS_NS    150
`define DMX5_T_RASMAX_NS 10000
`define DMX5_T_CAS_NS    75
`define DMX5_T_CAC_NS    75
`define DMX5_T_RP_NS     100
`define DMX5_T_CSR_NS    30
`define DMX5_T_CP_NS     60
`define DMX5_T_WP_NS     45
`define DMX5_T_CWL_NS    45
`define DMX5_T_REF_MS    4
`define DMX5_REF_ROWS    256
`define DMX5_T_PAUSE_US  200
`define DMX5_INIT_CYCLES 4'h8

// ----------------------------------------------------------------
// Controller policy
// ----------------------------------------------------------------
// Three filter stages plus the edge at which the filter output settles
`define DMX5_SYNC_LAT    4
`define DMX5_PAGE_MARGIN 64
`define DMX5_REF_WAIT    7'h40
`define DMX5_NIB_LAST    2'h3

`endif

// file: dmx5_ctrl.sv
`timescale 1ns/1ns
`include "dmx5_consts.svh"

module dmx5_ctrl #(
  parameter int P_PAUSE_CYC = (`DMX5_T_PAUSE_US * 1000) / `DMX5_CLK_NS
) (
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset,
  // User requests
  input  wire logic                 i_req_valid,
  input  wire dmx5_pkg::dmx5_req_t  i_req,
  output logic                      o_req_ready,
  // Read answers
  output logic                      o_rd_valid,
  output logic [`DMX5_DW-1:0]       o_rd_data,
  // Mode and status
  input  wire logic                 i_ras_only_ref,
  input  wire logic                 i_hidden_ref,
  input  wire logic                 i_nibble_mode,
  output logic                      o_init_done,
  // Memory module pins
  output dmx5_pkg::dmx5_pins_t      o_dram,
  input  wire logic [`DMX5_DW-1:0]  i_data_output_bits
);

  typedef logic [`DMX5_CNT_W-1:0] dmx5_cnt_t;

  function automatic dmx5_cnt_t ns2cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + `DMX5_CLK_NS - 1) / `DMX5_CLK_NS;
    if (c == 0)
      c = 1;
    return dmx5_cnt_t'(c);
  endfunction : ns2cyc

  function automatic dmx5_cnt_t max_cyc(input dmx5_cnt_t a, input dmx5_cnt_t b);
    return (a > b) ? a : b;
  endfunction : max_cyc

  function automatic logic [1:0] nib_next(input logic [1:0] p);
    return 2'(p + 2'h1);
  endfunction : nib_next

  localparam dmx5_cnt_t C_RCD    = ns2cyc(`DMX5_T_RCD_NS);
  localparam dmx5_cnt_t C_RAS    = ns2cyc(`DMX5_T_RAS_NS);
  localparam dmx5_cnt_t C_RASMAX = dmx5_cnt_t'(`DMX5_T_RASMAX_NS / `DMX5_CLK_NS);
  localparam dmx5_cnt_t C_CAS    = ns2cyc(`DMX5_T_CAS_NS);
  localparam dmx5_cnt_t C_RP     = ns2cyc(`DMX5_T_RP_NS);
  localparam dmx5_cnt_t C_CSR    = ns2cyc(`DMX5_T_CSR_NS);
  localparam dmx5_cnt_t C_CP     = ns2cyc(`DMX5_T_CP_NS);
  localparam dmx5_cnt_t C_ACC    = dmx5_cnt_t'(ns2cyc(`DMX5_T_CAC_NS) + `DMX5_SYNC_LAT);
  localparam dmx5_cnt_t C_RDCAS  = max_cyc(C_CAS, C_ACC);
  localparam dmx5_cnt_t C_WRP    = max_cyc(ns2cyc(`DMX5_T_WP_NS), ns2cyc(`DMX5_T_CWL_NS));
  localparam dmx5_cnt_t C_REF    = dmx5_cnt_t'((`DMX5_T_REF_MS * 1000000) / (`DMX5_REF_ROWS * `DMX5_CLK_NS));
  localparam dmx5_cnt_t C_PAGE   = dmx5_cnt_t'(C_RASMAX - `DMX5_PAGE_MARGIN);

  typedef enum logic [3:0] {
    ST_PAUSE, ST_IDLE, ST_RSET, ST_RAS, ST_CSET, ST_CAS, ST_WRP, ST_CHI,
    ST_CBR_CSR, ST_CBR_RAS, ST_HID_PRE, ST_HID_RAS, ST_PRE
  } dmx5_state_t;

  dmx5_state_t          st_q, st_d;
  dmx5_cnt_t            tmr_q, tmr_d;
  dmx5_cnt_t            ras_cnt_q, ras_hi_q, cas_lo_q, ref_div_q;
  logic [14:0]          pause_q;
  logic                 pause_done_q;
  logic [3:0]           init_left_q;
  logic                 ref_pend_q, ro_q, cbr_q;
  logic [7:0]           ref_row_q;
  logic [1:0]           burst_q;
  logic [6:0]           pend_age_q;
  logic [3:0]           cbr_seen_q;
  dmx5_pkg::dmx5_req_t  req_q;
  dmx5_pkg::dmx5_pins_t dram_d;
  logic [`DMX5_DW-1:0]  q_sync;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire                  tmr_zero  = (tmr_q == '0);
  wire                  ras_met   = (ras_cnt_q >= dmx5_cnt_t'(C_RAS - 1));
  wire                  pause_end = (pause_q == 15'(P_PAUSE_CYC - 1));
  wire                  ref_tick  = pause_done_q && (ref_div_q == dmx5_cnt_t'(C_REF - 1));
  wire                  rd_op     = (req_q.op != dmx5_pkg::DMX5_OP_WRITE);
  wire                  same_row  = (i_req.row == req_q.row);
  // Nibble partner must share all but the top bit pair and come next in order
  wire                  nib_seq   = ({i_req.col[8], i_req.row[8]} == nib_next({req_q.col[8], req_q.row[8]}))
                                    && (i_req.row[7:0] == req_q.row[7:0]) && (i_req.col[7:0] == req_q.col[7:0])
                                    && (burst_q != `DMX5_NIB_LAST);
  wire                  cont_ok   = !ref_pend_q && (ras_cnt_q < C_PAGE)
                                    && (i_nibble_mode ? nib_seq : same_row);
  assign o_init_done = pause_done_q && (init_left_q == '0);
  assign o_req_ready = o_init_done && !ref_pend_q
                       && ((st_q == ST_IDLE) || ((st_q == ST_CHI) && tmr_zero && cont_ok));
  wire                  req_fire  = i_req_valid && o_req_ready;
  wire                  rd_cap    = (st_q == ST_CAS) && tmr_zero && rd_op;
  // First cycle of a row strobe low with the column strobe already low
  wire                  cbr_fall  = !o_dram.ras_n && !o_dram.cas_n && (ras_hi_q != '0);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d  = st_q;
    tmr_d = tmr_zero ? '0 : dmx5_cnt_t'(tmr_q - 1);
    unique case (st_q)
      ST_PAUSE:   if (pause_end) st_d = ST_IDLE;
      ST_IDLE:
      begin
        if ((init_left_q != '0) || (ref_pend_q && !i_ras_only_ref))
        begin
          st_d  = ST_CBR_CSR;
          tmr_d = dmx5_cnt_t'(C_CSR - 1);
        end
        else if (ref_pend_q || req_fire)
        begin
          st_d  = ST_RSET;
          tmr_d = '0;
        end
      end
      ST_RSET:
      begin
        st_d  = ST_RAS;
        tmr_d = dmx5_cnt_t'(C_RCD - 1);
      end
      ST_RAS:
      begin
        if (ro_q ? ras_met : tmr_zero)
        begin
          st_d  = ro_q ? ST_PRE : ST_CSET;
          tmr_d = ro_q ? dmx5_cnt_t'(C_RP - 1) : '0;
        end
      end
      ST_CSET:
      begin
        st_d  = ST_CAS;
        tmr_d = rd_op ? dmx5_cnt_t'(C_RDCAS - 1) : dmx5_cnt_t'(C_CAS - 1);
      end
      ST_CAS:
      begin
        if (tmr_zero)
        begin
          if (req_q.op == dmx5_pkg::DMX5_OP_RMW)
          begin
            st_d  = ST_WRP;
            tmr_d = dmx5_cnt_t'(C_WRP - 1);
          end
          // The row must have met its low time before the strobe may rise for the hidden cycle
          else if (rd_op && i_hidden_ref && ref_pend_q && ras_met)
          begin
            st_d  = ST_HID_PRE;
            tmr_d = dmx5_cnt_t'(C_RP - 1);
          end
          else
          begin
            st_d  = ST_CHI;
            tmr_d = dmx5_cnt_t'(C_CP - 1);
          end
        end
      end
      ST_WRP:
      begin
        if (tmr_zero)
        begin
          st_d  = ST_CHI;
          tmr_d = dmx5_cnt_t'(C_CP - 1);
        end
      end
      ST_CHI:
      begin
        if (tmr_zero && req_fire)
          st_d = ST_CSET;
        else if (tmr_zero && ras_met)
        begin
          st_d  = ST_PRE;
          tmr_d = dmx5_cnt_t'(C_RP - 1);
        end
      end
      ST_CBR_CSR: if (tmr_zero) st_d = ST_CBR_RAS;
      ST_HID_PRE: if (tmr_zero) st_d = ST_HID_RAS;
      ST_CBR_RAS, ST_HID_RAS:
      begin
        if (ras_met)
        begin
          st_d  = ST_PRE;
          tmr_d = dmx5_cnt_t'(C_RP - 1);
        end
      end
      ST_PRE:
      begin
        if (tmr_zero)
          st_d = (cbr_q && (init_left_q != '0)) ? ST_CBR_RAS : ST_IDLE;
      end
    endcase
  end

  wire        enter     = (st_d != st_q);
  wire        ro_start  = (st_q == ST_IDLE) && (st_d == ST_RSET) && ref_pend_q;
  wire        ref_start = ro_start || (enter && ((st_d == ST_CBR_CSR) || (st_d == ST_HID_PRE)));
  wire        ro_d      = ro_start ? 1'b1 : ((st_q == ST_IDLE) ? 1'b0 : ro_q);
  wire        cbr_d     = (st_d == ST_CBR_CSR) || (st_d == ST_CBR_RAS) || ((st_d == ST_PRE) && cbr_q);
  wire [3:0]  init_d    = (pause_end && !pause_done_q) ? `DMX5_INIT_CYCLES
                          : ((enter && (st_d == ST_CBR_RAS) && (init_left_q != '0)) ? 4'(init_left_q - 4'h1)
                          : init_left_q);
  wire [7:0]  ref_row_d = ro_start ? 8'(ref_row_q + 8'h01) : ref_row_q;
  wire dmx5_pkg::dmx5_req_t req_d = req_fire ? i_req : req_q;

  // ----------------------------------------------------------------
  // Pin decode, registered below
  // ----------------------------------------------------------------
  // One module only, so the column strobe needs no decode here
  wire ras_lo = (st_d inside {ST_RAS, ST_CSET, ST_CAS, ST_WRP, ST_CHI, ST_CBR_RAS, ST_HID_RAS});
  wire cas_lo = (st_d inside {ST_CAS, ST_WRP, ST_CBR_CSR, ST_CBR_RAS, ST_HID_PRE, ST_HID_RAS})
                || ((st_d == ST_PRE) && cbr_d && (init_d != '0));
  // Early write drops write control one cycle ahead of the column strobe
  wire we_lo  = ((st_d inside {ST_CSET, ST_CAS}) && (req_d.op == dmx5_pkg::DMX5_OP_WRITE)) || (st_d == ST_WRP);
  // Row bits in row states, refresh row on the low eight pins
  wire [`DMX5_AW-1:0] addr_d = (st_d inside {ST_RSET, ST_RAS})
                               ? (ro_d ? {1'b0, ref_row_d} : req_d.row) : req_d.col;
  assign dram_d = '{ras_n: !ras_lo, cas_n: !cas_lo, we_n: !we_lo,
                    mux_address_pins: addr_d, data_input_bits: req_d.wdata};

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      st_q   <= ST_PAUSE;
      tmr_q  <= '0;
      req_q  <= '0;
      o_dram <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
    end
    else
    begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      req_q  <= req_d;
      o_dram <= dram_d;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      pause_q      <= '0;
      pause_done_q <= 1'b0;
      init_left_q  <= '0;
      ro_q         <= 1'b0;
      cbr_q        <= 1'b0;
      ref_row_q    <= '0;
      burst_q      <= '0;
    end
    else
    begin
      pause_q      <= pause_done_q ? pause_q : 15'(pause_q + 15'h0001);
      pause_done_q <= pause_done_q || pause_end;
      init_left_q  <= init_d;
      ro_q         <= ro_d;
      cbr_q        <= cbr_d;
      ref_row_q    <= ref_row_d;
      burst_q      <= (st_d == ST_RSET) ? 2'h0 : ((enter && (st_q == ST_CHI) && (st_d == ST_CSET)) ? 2'(burst_q + 2'h1)
                      : burst_q);
    end
  end

  // A new tick wins over the clearing start of a refresh
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      ref_div_q  <= '0;
      ref_pend_q <= 1'b0;
    end
    else
    begin
      ref_div_q  <= (ref_tick || !pause_done_q) ? '0 : dmx5_cnt_t'(ref_div_q + 1);
      ref_pend_q <= ref_tick || (ref_pend_q && !ref_start);
    end
  end

  // Pin-level time counters, refresh wait age and CBR fall count; the timing checks read them too
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      ras_cnt_q  <= '0;
      ras_hi_q   <= '0;
      cas_lo_q   <= '0;
      pend_age_q <= '0;
      cbr_seen_q <= '0;
    end
    else
    begin
      cbr_seen_q <= (cbr_fall && (cbr_seen_q != '1)) ? 4'(cbr_seen_q + 4'h1) : cbr_seen_q;
      ras_cnt_q  <= o_dram.ras_n ? '0 : ((ras_cnt_q == '1) ? ras_cnt_q : dmx5_cnt_t'(ras_cnt_q + 1));
      ras_hi_q   <= !o_dram.ras_n ? '0 : ((ras_hi_q == '1) ? ras_hi_q : dmx5_cnt_t'(ras_hi_q + 1));
      cas_lo_q   <= o_dram.cas_n ? '0 : ((cas_lo_q == '1) ? cas_lo_q : dmx5_cnt_t'(cas_lo_q + 1));
      pend_age_q <= !ref_pend_q ? '0 : ((pend_age_q == '1) ? pend_age_q : 7'(pend_age_q + 7'h01));
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  dmx5_sync3 u_qsync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_async (i_data_output_bits),
    .o_sync  (q_sync)
  );

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end
    else
    begin
      o_rd_valid <= rd_cap;
      o_rd_data  <= rd_cap ? q_sync : o_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  a_row_addr_hold: assert property ($fell(o_dram.ras_n) && o_dram.cas_n
    |-> $stable(o_dram.mux_address_pins)) else $error("row address moved at row strobe fall");
  a_col_addr_hold: assert property ($fell(o_dram.cas_n) && !o_dram.ras_n
    |-> $stable(o_dram.mux_address_pins)) else $error("column address moved at column strobe fall");
  a_early_write: assert property ($fell(o_dram.cas_n) && !o_dram.we_n && !o_dram.ras_n
    |-> !$past(o_dram.we_n)) else $error("early write control not ahead of column strobe");
  a_rmw_read_first: assert property ($fell(o_dram.we_n) && !o_dram.cas_n
    |-> o_rd_valid) else $error("delayed write strobe before read data was taken");
  a_read_access: assert property (o_rd_valid
    |-> ($past(cas_lo_q) + 1) >= C_ACC) else $error("read sampled before access time");
  a_ras_precharge: assert property ($fell(o_dram.ras_n)
    |-> (ras_hi_q >= C_RP) && (o_dram.cas_n || (cas_lo_q >= C_CSR))) else $error("precharge or csr too short");
  a_ras_low_span: assert property ($rose(o_dram.ras_n)
    |-> (ras_cnt_q >= C_RAS) && (ras_cnt_q <= C_RASMAX)) else $error("row strobe low time out of range");
  a_ro_cas_high: assert property (ro_q && !o_dram.ras_n
    |-> o_dram.cas_n && o_dram.we_n) else $error("column strobe low during row-only refresh");
  a_ref_wait: assert property (ref_pend_q
    |-> pend_age_q < `DMX5_REF_WAIT) else $error("refresh held off too long");
  a_ready_init: assert property (o_req_ready
    |-> cbr_seen_q >= `DMX5_INIT_CYCLES) else $error("request accepted before initialisation");

  c_rmw: cover property ((st_q == ST_WRP) ##1 (st_q == ST_CHI));
  c_page: cover property ((st_q == ST_CHI) && (st_d == ST_CSET));
  c_hidden: cover property ((st_q == ST_HID_RAS) && o_rd_valid == 1'b0);
  c_early_write: cover property ($fell(o_dram.cas_n) && !o_dram.we_n);

endmodule : dmx5_ctrl

// file: dmx5_mem_model.sv
`timescale 1ns/1ns
module dmx5_mem_model (
  // Strobes and write control
  input  wire logic       i_ras_n,
  input  wire logic       i_cas_n,
  input  wire logic       i_we_n,
  // Address, data and nibble mode
  input  wire logic [8:0] i_addr,
  input  wire logic [4:0] i_d,
  input  wire logic       i_nibble,
  output logic      [4:0] o_q
);
  // ----------------------------------------------------------------
  // Five slices in lockstep, one array word per location
  // ----------------------------------------------------------------
  logic [4:0] mem [int];
  logic [8:0] row_q;
  logic [8:0] col_q;
  logic [4:0] rd_q;
  logic       early_q;
  logic       valid_q;
  logic       first_q;
  int         key;

  initial
  begin
    rd_q = 5'h00;
    valid_q = 1'b0;
    early_q = 1'b0;
    first_q = 1'b0;
  end

  always @(negedge i_ras_n)
  begin
    first_q = 1'b1;
    if (i_cas_n)
      row_q = i_addr;  // with column low the pins are ignored
  end

  always @(negedge i_cas_n)
  begin
    valid_q = 1'b0;
    if (!i_ras_n)
    begin
      if (first_q || !i_nibble)
        col_q = i_addr;
      else
        {col_q[8], row_q[8]} = {col_q[8], row_q[8]} + 2'h1;
      first_q = 1'b0;
      key = {row_q, col_q};
      early_q = !i_we_n;
      if (early_q)
        mem[key] = i_d;
      else
      begin
        #75;
        rd_q = mem.exists(key) ? mem[key] : 5'h00;
        valid_q = !i_cas_n;
      end
    end
  end

  // Reads never store the data pins
  always @(negedge i_we_n)
    if (!i_cas_n && !i_ras_n && !early_q)
      mem[key] = i_d;

  always @(posedge i_cas_n)
    valid_q = 1'b0;

  // Floating outputs show the inverse of the last value, never a held copy
  assign o_q = valid_q ? rd_q : ~rd_q;
endmodule : dmx5_mem_model

// file: dmx5_pkg.sv
`include "dmx5_consts.svh"

package dmx5_pkg;

  typedef enum logic [1:0] {DMX5_OP_READ, DMX5_OP_WRITE, DMX5_OP_RMW} dmx5_op_t;

  typedef struct packed {
    dmx5_op_t              op;
    logic [`DMX5_AW-1:0]   row;
    logic [`DMX5_AW-1:0]   col;
    logic [`DMX5_DW-1:0]   wdata;
  } dmx5_req_t;

  typedef struct packed {
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic [`DMX5_AW-1:0]   mux_address_pins;
    logic [`DMX5_DW-1:0]   data_input_bits;
  } dmx5_pins_t;

endpackage : dmx5_pkg

// file: dmx5_sync3.sv
`timescale 1ns/1ns
`include "dmx5_consts.svh"

module dmx5_sync3 (
  // Clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_reset,
  // Asynchronous bits in, settled bits out
  input  wire logic [`DMX5_DW-1:0] i_async,
  output logic      [`DMX5_DW-1:0] o_sync
);

  logic [`DMX5_DW-1:0] s1_q;
  logic [`DMX5_DW-1:0] s2_q;
  logic [`DMX5_DW-1:0] s3_q;

  // A bit moves only once the last two stages agree, so a glitch is not taken
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      o_sync <= '0;
    end
    else
    begin
      s1_q   <= i_async;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      o_sync <= (s2_q & s3_q) | (o_sync & (s2_q | s3_q));
    end
  end

endmodule : dmx5_sync3

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                 i_mclk;
  logic                 i_reset;
  logic                 i_req_valid;
  dmx5_pkg::dmx5_req_t  i_req;
  logic                 i_ras_only_ref;
  logic                 i_hidden_ref;
  logic                 i_nibble_mode;
  logic                 o_req_ready;
  logic                 o_rd_valid;
  logic [4:0]           o_rd_data;
  logic                 o_init_done;
  dmx5_pkg::dmx5_pins_t pins;
  logic [4:0]           q;
  logic [4:0]           ref_mem [int];
  logic [4:0]           exp_q [$];
  logic [8:0]           pool [3] = '{9'h000, 9'h1ff, 9'h0a5};
  dmx5_pkg::dmx5_req_t  cur;
  logic [7:0]           prev_row;
  logic                 have_prev, ras_q, cas_q, busy;
  int                   err_total, tests_run, n_cbr, n_ros, seed_v;

  // ----------------------------------------------------------------
  // Clock, design and memory
  // ----------------------------------------------------------------
  initial i_mclk = 1'b0;
  always #4 i_mclk = ~i_mclk;

  dmx5_ctrl #(.P_PAUSE_CYC(50)) u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .i_ras_only_ref(i_ras_only_ref), .i_hidden_ref(i_hidden_ref), .i_nibble_mode(i_nibble_mode),
    .o_init_done(o_init_done), .o_dram(pins), .i_data_output_bits(q));

  dmx5_mem_model u_mem (.i_ras_n(pins.ras_n), .i_cas_n(pins.cas_n), .i_we_n(pins.we_n),
    .i_addr(pins.mux_address_pins), .i_d(pins.data_input_bits), .i_nibble(i_nibble_mode), .o_q(q));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : check

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  always @(negedge i_mclk)
  begin
    if (o_rd_valid === 1'b1)
      if (exp_q.size() == 0)
        check(1'b1, 1'b0, "stray read answer");
      else
        check(o_rd_data, exp_q.pop_front(), "read data");
    if (ras_q === 1'b1 && pins.ras_n === 1'b0)
      if (pins.cas_n === 1'b0)
        n_cbr++;
      else if (!busy)
      begin
        n_ros++;
        check(pins.mux_address_pins[8], 1'b0, "row refresh top bit");
        if (have_prev)
          check(pins.mux_address_pins[7:0], 8'(prev_row + 8'h01), "row refresh step");
        prev_row = pins.mux_address_pins[7:0];
        have_prev = 1'b1;
      end
    if (cas_q === 1'b1 && pins.cas_n === 1'b0 && pins.ras_n === 1'b0 && busy)
    begin
      check(pins.we_n, cur.op != dmx5_pkg::DMX5_OP_WRITE, "write control at column strobe");
      if (!i_nibble_mode)
        check(pins.mux_address_pins, cur.col, "column address");
      if (cur.op == dmx5_pkg::DMX5_OP_WRITE)
        check(pins.data_input_bits, cur.wdata, "early write data");
    end
    ras_q = pins.ras_n;
    cas_q = pins.cas_n;
  end

  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  task automatic do_reset;
    int i;
    busy = 1'b1;
    @(posedge i_mclk) i_reset <= 1'b1;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    check(pins.ras_n & pins.cas_n & pins.we_n, 1'b1, "strobes idle in reset");
    check(o_init_done, 1'b0, "ready during reset");
    n_cbr = 0;
    @(posedge i_mclk) i_reset <= 1'b0;
    for (i = 0; i < 2000 && o_req_ready !== 1'b1; i++)
      @(negedge i_mclk);
    check(o_init_done, 1'b1, "init finished");
    check(o_req_ready, 1'b1, "ready after init");
    if (o_req_ready !== 1'b1)
      close_out();
    check(n_cbr == 8, 1'b1, "eight init cycles");
    // Pause, then eight row strobes of 19 cycles with 13 cycles of precharge between
    check(i >= 50 + 8 * 19 + 7 * 13, 1'b1, "pause before init cycles");
  endtask : do_reset

  task automatic send(input dmx5_pkg::dmx5_req_t rq);
    int i;
    i_req <= rq;
    i_req_valid <= 1'b1;
    @(negedge i_mclk);
    for (i = 0; i < 600 && o_req_ready !== 1'b1; i++)
      @(negedge i_mclk);
    if (o_req_ready !== 1'b1)
    begin
      check(1'b0, 1'b1, "request never taken");
      close_out();
    end
    @(posedge i_mclk);
    cur = rq;
    if (rq.op != dmx5_pkg::DMX5_OP_WRITE)
      exp_q.push_back(ref_mem[{rq.row, rq.col}]);
    if (rq.op != dmx5_pkg::DMX5_OP_READ)
      ref_mem[{rq.row, rq.col}] = rq.wdata;
  endtask : send

  task automatic run_ops(input int n, input logic nib, input logic hid);
    dmx5_pkg::dmx5_req_t rq;
    int k;
    @(posedge i_mclk);
    i_nibble_mode <= nib;
    i_hidden_ref <= hid;
    rq = '0;
    for (k = 0; k < n; k++)
    begin
      case ($urandom_range(2))
        0: {rq.row, rq.col} = {pool[$urandom_range(2)], pool[$urandom_range(2)]};
        1: rq.col = pool[$urandom_range(2)];
        default: {rq.col[8], rq.row[8]} = {rq.col[8], rq.row[8]} + 2'h1;
      endcase
      rq.wdata = 5'($urandom);
      if (ref_mem.exists({rq.row, rq.col}))
        rq.op = dmx5_pkg::dmx5_op_t'($urandom_range(2));
      else
        rq.op = dmx5_pkg::DMX5_OP_WRITE;
      send(rq);
    end
    i_req_valid <= 1'b0;
    @(negedge i_mclk);
    for (k = 0; k < 600 && (exp_q.size() != 0 || o_req_ready !== 1'b1); k++)
      @(negedge i_mclk);
    check(exp_q.size() == 0, 1'b1, "all reads answered");
    check(o_req_ready, 1'b1, "ready after the last request");
    if (exp_q.size() != 0 || o_req_ready !== 1'b1)
      close_out();
  endtask : run_ops

  // Idle spans cover two refresh intervals, so at least two refreshes show
  task automatic idle(input logic ras_only);
    int b;
    @(posedge i_mclk) i_ras_only_ref <= ras_only;
    busy = 1'b0;
    have_prev = 1'b0;
    b = ras_only ? n_ros : n_cbr;
    repeat (4000) @(posedge i_mclk);
    busy = 1'b1;
    check(((ras_only ? n_ros : n_cbr) - b) >= 2, 1'b1, "periodic refresh");
  endtask : idle

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_reset = 1'b1;
    i_req_valid = 1'b0;
    i_req = '0;
    i_ras_only_ref = 1'b0;
    i_hidden_ref = 1'b0;
    i_nibble_mode = 1'b0;
    err_total = 0;
    tests_run = 0;
    n_cbr = 0;
    n_ros = 0;
    busy = 1'b1;
    have_prev = 1'b0;
    ras_q = 1'b1;
    cas_q = 1'b1;
    cur = '0;
    seed_v = $urandom(32'h1583_5023);
    do_reset();
    run_ops(40, 1'b0, 1'b0);
    run_ops(40, 1'b1, 1'b1);
    idle(1'b1);
    idle(1'b0);
    repeat (4)
      run_ops(30, 1'($urandom_range(1)), 1'($urandom_range(1)));
    do_reset();
    run_ops(30, 1'b0, 1'b1);
    close_out();
  end
endmodule : tb_top
